// file: pkg/pftbc_pkg.sv
package pftbc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS      = 100;
  // Timing registers count in steps of 0.1 ms
  localparam int TICK_NS_DEF = 100000;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int          AW       = 8;
  localparam logic [7:0]  A_CTRL   = 8'h00;
  localparam logic [7:0]  A_GDLY   = 8'h04;
  localparam logic [7:0]  A_GON    = 8'h08;
  localparam logic [7:0]  A_PER    = 8'h0C;
  localparam logic [7:0]  A_STAT   = 8'h10;
  localparam logic [7:0]  A_IRQ    = 8'h14;
  localparam logic [7:0]  A_MASK   = 8'h18;
  localparam logic [1:0]  R_OKAY   = 2'h0;
  localparam logic [1:0]  R_SLVERR = 2'h2;

  // Control register fields
  localparam int B_ERR_EN = 0;
  localparam int B_LEVEL  = 1;
  localparam int B_POL    = 2;
  localparam int F_SCN    = 4;
  localparam int F_SC     = 8;
  localparam int F_SD     = 12;
  localparam int F_RTY    = 16;
  localparam int SW       = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;

  // Gate timing, 0.1 ms steps: 1.0 ms, 5.0 ms, 10.0 ms
  localparam int          TW       = 17;
  localparam logic [15:0] GDLY_RST = 16'h000A;
  localparam logic [15:0] GON_RST  = 16'h0032;
  localparam logic [16:0] PER_RST  = 17'h00064;

  // Interrupt bits
  localparam int IW      = 3;
  localparam int I_DONE  = 0;
  localparam int I_REFUS = 1;
  localparam int I_GATE  = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RD_IDLE = 3'b001,
    RD_READ = 3'b010,
    RD_HOLD = 3'b100
  } pftbc_rd_t;

  typedef enum logic [3:0] {
    OS_IDLE = 4'b0001,
    OS_DLY  = 4'b0010,
    OS_GATE = 4'b0100,
    OS_REST = 4'b1000
  } pftbc_os_t;

  typedef enum logic [1:0] {
    K_SINGLE = 2'h0,
    K_CONT   = 2'h1,
    K_LEVEL  = 2'h2
  } pftbc_kind_t;

endpackage

// file: src/pftbc_top.sv
`timescale 1ns/1ps
// What this block does
// - While busy, single read strobes are ignored and start no reading.
// - With error reporting on, a strobe during busy raises the error output.
// - A raised error output drops at the next strobe taken while idle.
// - With error reporting off, refused strobes leave the error output low.
// - Busy drops when the reading operation has completed.
// - Continuous mode repeats readings while repeat level stays high.
// - Level mode repeats readings while level high, stopping on a pass.
// - Level mode without a pass outputs fail when the level is released.
// - Scene jump levels read their own scene 0..9 with level behaviour.
// - A polarity setting picks pass or fail as the asserted output.
// - The host uses the same parallel settings as this device.
// - By default the pass/fail output is asserted for a fail.
// - Gate rises a programmable 1.0..1000.0 ms after the result is driven.
// - Gate stays high a programmable 1.0..1000.0 ms, default 5.0 ms.
// - Result period 2.0..10000.0 ms, longer than gate delay plus on time.
module pftbc_top
  import pftbc_pkg::*;
#(
  parameter int TICK_NS = TICK_NS_DEF
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic          single_read_strobe,
  input  wire logic          repeat_read_level,
  input  wire logic          scene_jump_level_one,
  input  wire logic          scene_jump_level_two,
  input  wire logic          read_done,
  input  wire logic          read_pass,
  output logic               read_start,
  output logic [SW-1:0]      read_scene,
  output logic               busy,
  output logic               error_out,
  output logic               pass_fail_output,
  output logic               gate_out,
  output logic               irq
);

  localparam int          TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [15:0] TICK_END = 16'(TICK_CYC - 1);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pin_raw;
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic       single_prev;
  assign pin_raw = {scene_jump_level_two, scene_jump_level_one,
                    repeat_read_level, single_read_strobe};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
        end else begin
          sync_a[gi] <= pin_raw[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) single_prev <= 1'b0;
    else          single_prev <= sync_b[0];
  end

  logic s_edge;
  assign s_edge = sync_b[0] & ~single_prev;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [31:0]   ctrl;
  logic [15:0]   gdly;
  logic [15:0]   gon;
  logic [TW-1:0] per;
  logic [IW-1:0] irq_stat;
  logic [IW-1:0] irq_mask;
  logic [AW-1:0] wr_addr;
  logic [31:0]   wr_data;
  logic [3:0]    wr_strb;
  logic          aw_full;
  logic          w_full;
  logic          wr_fire;
  logic [31:0]   m_gdly;
  logic [31:0]   m_gon;
  logic [31:0]   m_per;
  logic [31:0]   m_mask;

  function automatic logic mapped(input logic [AW-1:0] a);
    mapped = (a == A_CTRL) || (a == A_GDLY) || (a == A_GON) ||
             (a == A_PER) || (a == A_STAT) || (a == A_IRQ) ||
             (a == A_MASK);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    for (int i = 0; i < 4; i++)
      merge[8*i +: 8] = strb[i] ? new_v[8*i +: 8] : old_v[8*i +: 8];
  endfunction

  assign wr_fire = aw_full & w_full & ~s_axi_bvalid;
  assign m_gdly  = merge({16'h0000, gdly}, wr_data, wr_strb);
  assign m_gon   = merge({16'h0000, gon}, wr_data, wr_strb);
  assign m_per   = merge({15'h0000, per}, wr_data, wr_strb);
  assign m_mask  = merge({29'h0, irq_mask}, wr_data, wr_strb);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= R_OKAY;
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      wr_addr       <= '0;
      wr_data       <= '0;
      wr_strb       <= '0;
    end else begin
      s_axi_awready <= ~aw_full & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~w_full & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid & s_axi_awready) begin
        aw_full <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_full  <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_full      <= 1'b0;
        w_full       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(wr_addr) ? R_OKAY : R_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl     <= CTRL_RST;
      gdly     <= GDLY_RST;
      gon      <= GON_RST;
      per      <= PER_RST;
      irq_mask <= '0;
    end else if (wr_fire) begin
      case (wr_addr)
        A_CTRL:  ctrl     <= merge(ctrl, wr_data, wr_strb);
        A_GDLY:  gdly     <= m_gdly[15:0];
        A_GON:   gon      <= m_gon[15:0];
        A_PER:   per      <= m_per[TW-1:0];
        A_MASK:  irq_mask <= m_mask[IW-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Reading control
  // ----------------------------------------------------------------
  pftbc_rd_t   rd_state;
  pftbc_kind_t kind;
  logic [1:0]  src;
  logic [3:0]  rty;
  logic        lvl_now;
  logic        pub;
  logic        pub_pass;

  always_comb begin
    case (src)
      2'h1:    lvl_now = sync_b[1];
      2'h2:    lvl_now = sync_b[2];
      2'h3:    lvl_now = sync_b[3];
      default: lvl_now = 1'b0;
    endcase
  end

  // Single strobes win over levels; a scene jump reads its own scene
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state   <= RD_IDLE;
      kind       <= K_SINGLE;
      src        <= 2'h0;
      rty        <= '0;
      read_start <= 1'b0;
      read_scene <= '0;
      busy       <= 1'b0;
      pub        <= 1'b0;
      pub_pass   <= 1'b0;
    end else begin
      read_start <= 1'b0;
      pub        <= 1'b0;
      case (rd_state)
        RD_IDLE, RD_HOLD: begin
          if (s_edge) begin
            rd_state   <= RD_READ;
            busy       <= 1'b1;
            read_start <= 1'b1;
            kind       <= K_SINGLE;
            src        <= 2'h0;
            rty        <= ctrl[F_RTY +: 4];
            read_scene <= ctrl[F_SCN +: SW];
          end else if (rd_state == RD_HOLD) begin
            if (!lvl_now) rd_state <= RD_IDLE;
          end else if (sync_b[1] | sync_b[2] | sync_b[3]) begin
            rd_state   <= RD_READ;
            busy       <= 1'b1;
            read_start <= 1'b1;
            if (sync_b[1]) begin
              kind       <= ctrl[B_LEVEL] ? K_LEVEL : K_CONT;
              src        <= 2'h1;
              read_scene <= ctrl[F_SCN +: SW];
            end else if (sync_b[2]) begin
              kind       <= K_LEVEL;
              src        <= 2'h2;
              read_scene <= ctrl[F_SC +: SW];
            end else begin
              kind       <= K_LEVEL;
              src        <= 2'h3;
              read_scene <= ctrl[F_SD +: SW];
            end
          end
        end
        RD_READ: begin
          // Strobes seen here are dropped: nothing below looks at them
          if (read_done) begin
            case (kind)
              K_CONT: begin
                pub      <= 1'b1;
                pub_pass <= read_pass;
                if (lvl_now) begin
                  read_start <= 1'b1;
                end else begin
                  rd_state <= RD_IDLE;
                  busy     <= 1'b0;
                end
              end
              K_LEVEL: begin
                if (read_pass) begin
                  pub      <= 1'b1;
                  pub_pass <= 1'b1;
                  busy     <= 1'b0;
                  rd_state <= lvl_now ? RD_HOLD : RD_IDLE;
                end else if (lvl_now) begin
                  read_start <= 1'b1;
                end else begin
                  pub      <= 1'b1;
                  pub_pass <= 1'b0;
                  busy     <= 1'b0;
                  rd_state <= RD_IDLE;
                end
              end
              default: begin
                if (read_pass || rty == 4'h0) begin
                  pub      <= 1'b1;
                  pub_pass <= read_pass;
                  busy     <= 1'b0;
                  rd_state <= RD_IDLE;
                end else begin
                  rty        <= rty - 4'h1;
                  read_start <= 1'b1;
                end
              end
            endcase
          end
        end
        default: rd_state <= RD_IDLE;
      endcase
    end
  end

  // Error flag follows strobes only, so it holds until the next accepted strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      error_out <= 1'b0;
    end else if (s_edge) begin
      if (!busy)               error_out <= 1'b0;
      else if (ctrl[B_ERR_EN]) error_out <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Result output and gate timing
  // ----------------------------------------------------------------
  pftbc_os_t     os_state;
  logic          pend;
  logic          pend_pass;
  logic [15:0]   pre;
  logic [TW-1:0] elapsed;
  logic [TW-1:0] gate_end;
  logic          gate_rise;

  assign gate_end  = {1'b0, gdly} + {1'b0, gon};
  assign gate_rise = (os_state == OS_DLY) && (elapsed >= {1'b0, gdly});

  // A result arriving mid-period waits; only the newest one is kept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      os_state         <= OS_IDLE;
      pend             <= 1'b0;
      pend_pass        <= 1'b0;
      pre              <= '0;
      elapsed          <= '0;
      gate_out         <= 1'b0;
      pass_fail_output <= 1'b0;
    end else begin
      if (pre == TICK_END) begin
        pre     <= '0;
        elapsed <= elapsed + 17'h00001;
      end else begin
        pre <= pre + 16'h0001;
      end
      if (pub) begin
        pend      <= 1'b1;
        pend_pass <= pub_pass;
      end
      case (os_state)
        OS_IDLE: begin
          if (pend) begin
            if (!pub) pend <= 1'b0;
            pass_fail_output <= ctrl[B_POL] ? pend_pass
                                            : ~pend_pass;
            pre      <= '0;
            elapsed  <= '0;
            os_state <= OS_DLY;
          end
        end
        OS_DLY: begin
          if (gate_rise) begin
            gate_out <= 1'b1;
            os_state <= OS_GATE;
          end
        end
        OS_GATE: begin
          if (elapsed >= gate_end) begin
            gate_out <= 1'b0;
            os_state <= OS_REST;
          end
        end
        OS_REST: begin
          // A period shorter than delay plus gate ends at the gate fall
          if (elapsed >= per) os_state <= OS_IDLE;
        end
        default: os_state <= OS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Interrupts and read data
  // ----------------------------------------------------------------
  logic [IW-1:0] ev;
  logic [IW-1:0] w1c;
  logic [31:0]   rd_mux;

  assign ev  = {gate_rise, s_edge & busy, pub};
  assign w1c = (wr_fire && wr_addr == A_IRQ && wr_strb[0]) ?
               wr_data[IW-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= '0;
      irq      <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~w1c) | ev;
      irq      <= |(((irq_stat & ~w1c) | ev) & irq_mask);
    end
  end

  always_comb begin
    case (s_axi_araddr)
      A_CTRL:  rd_mux = ctrl;
      A_GDLY:  rd_mux = {16'h0000, gdly};
      A_GON:   rd_mux = {16'h0000, gon};
      A_PER:   rd_mux = {15'h0000, per};
      A_STAT:  rd_mux = {24'h000000, read_scene, gate_out,
                         pass_fail_output, error_out, busy};
      A_IRQ:   rd_mux = {29'h0, irq_stat};
      A_MASK:  rd_mux = {29'h0, irq_mask};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= R_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= mapped(s_axi_araddr) ? R_OKAY : R_SLVERR;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_busy_refuse: assert property (
    busy && s_edge && !read_done |=> !read_start)
    else $error("strobe during busy started a reading");
  a_err_raise: assert property (
    busy && s_edge && ctrl[B_ERR_EN] |=> error_out)
    else $error("refused strobe did not raise error");
  a_err_drop: assert property (
    !busy && s_edge |=> !error_out && busy && read_start)
    else $error("accepted strobe did not clear error");
  a_err_quiet: assert property (
    $rose(error_out) |-> $past(ctrl[B_ERR_EN]) && $past(busy))
    else $error("error rose with reporting off or idle");
  a_busy_end: assert property (
    busy && read_done && kind == K_SINGLE && read_pass
    |=> !busy && rd_state == RD_IDLE)
    else $error("busy stayed after reading completed");
  a_cont_repeat: assert property (
    busy && read_done && kind == K_CONT && lvl_now |=> read_start && busy)
    else $error("continuous mode did not repeat");
  a_level_stop: assert property (
    busy && read_done && kind == K_LEVEL && read_pass
    |=> !busy && !read_start && pub && pub_pass)
    else $error("level mode did not stop on pass");
  a_level_fail: assert property (
    busy && read_done && kind == K_LEVEL && !read_pass && !lvl_now
    |=> pub && !pub_pass)
    else $error("level release gave no fail result");
  a_scene_jump: assert property (
    rd_state == RD_IDLE && !s_edge && !sync_b[1] && sync_b[2]
    |=> read_start && kind == K_LEVEL &&
        read_scene == $past(ctrl[F_SC +: SW]))
    else $error("scene jump read wrong scene or mode");
  a_pf_polarity: assert property (
    os_state == OS_IDLE && pend && !wr_fire
    |=> pass_fail_output == (ctrl[B_POL] ? $past(pend_pass)
                                         : !$past(pend_pass)))
    else $error("pass/fail output polarity wrong");
  a_gate_delay: assert property (
    $rose(gate_out) |-> elapsed >= {1'b0, gdly} && pre <= 16'h0001)
    else $error("gate rose before its delay");
  a_gate_width: assert property (
    $fell(gate_out) |-> elapsed >= gate_end)
    else $error("gate fell early");
  a_busy_start: assert property (
    rd_state != RD_READ ##1 rd_state == RD_READ |-> busy)
    else $error("reading without busy");

endmodule

// file: tb/pftbc_engine.sv
`timescale 1ns/1ps
// Image engine stand-in: one result per start, after dly+1 cycles
module pftbc_engine (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       read_start,
  input  wire logic [7:0] dly,
  input  wire logic       pass_in,
  output logic            read_done,
  output logic            read_pass
);
  logic [7:0] cnt;
  logic       run;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run <= 1'h0;
      cnt <= 8'h00;
      read_done <= 1'h0;
      read_pass <= 1'h0;
    end else begin
      read_done <= 1'h0;
      // Flag toggles outside a result so it is never a stale match
      read_pass <= ~read_pass;
      if (read_start) begin
        run <= 1'h1;
        cnt <= dly;
      end else if (run && cnt == 8'h00) begin
        run <= 1'h0;
        read_done <= 1'h1;
        read_pass <= pass_in;
      end else if (run) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import pftbc_pkg::*;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [AW-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic single_read_strobe = 1'h0, repeat_read_level = 1'h0;
  logic scene_jump_level_one = 1'h0, scene_jump_level_two = 1'h0;
  logic read_done, read_pass, read_start, busy, error_out;
  logic pass_fail_output, gate_out, irq;
  logic [SW-1:0] read_scene;
  logic [7:0] dly = 8'h03;
  logic pass_in = 1'h1;
  int n_mismatch = 0, checked = 0, nstart = 0, n0;
  logic [31:0] d;
  logic [1:0] r;

  always #50 aclk = ~aclk;
  always @(posedge aclk) if (read_start === 1'h1) nstart <= nstart + 1;

  // 10 cycles per timing tick keeps gate timing short
  pftbc_top #(.TICK_NS(1000)) pftbc_top_i (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .single_read_strobe, .repeat_read_level,
    .scene_jump_level_one, .scene_jump_level_two, .read_done,
    .read_pass, .read_start, .read_scene, .busy, .error_out,
    .pass_fail_output, .gate_out, .irq);
  pftbc_engine pftbc_engine_i (.aclk, .aresetn, .read_start, .dly,
    .pass_in, .read_done, .read_pass);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, R_OKAY, "write response");
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    cyc(1);
  endtask
  task automatic pulse();
    single_read_strobe <= 1'h1;
    cyc(4);
    single_read_strobe <= 1'h0;
    cyc(1);
  endtask
  // Waits for busy (w=0) or gate (w=1) to reach v; returns cycles
  task automatic wt(input int w, input logic v, output int t);
    t = 0;
    while (((w == 0) ? busy : gate_out) !== v && t < 3000) begin
      @(posedge aclk);
      t++;
    end
    chk(t < 3000, 1'h1, "wait timed out");
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    rd(A_CTRL);
    chk(d, CTRL_RST, "ctrl reset");
    rd(A_GON);
    chk(d, {16'h0, GON_RST}, "gate on reset");
    rd(A_PER);
    chk(d, {15'h0, PER_RST}, "period reset");
    rd(8'h1C);
    chk({d, r}, {32'h0, R_SLVERR}, "unmapped read");
    wr(A_GDLY, 32'h2);
    wr(A_GON, 32'h3);
    wr(A_PER, 32'h8);
    rd(A_GDLY);
    chk(d, 32'h2, "gate delay readback");
    $display("test regs done");
  endtask
  task automatic t_single();
    int t, h;
    n0 = nstart;
    single_read_strobe <= 1'h1;
    wt(0, 1'h1, t);
    single_read_strobe <= 1'h0;
    chk(t, 4, "busy late after strobe");
    wt(0, 1'h0, t);
    chk(nstart - n0, 1, "one reading per strobe");
    wt(1, 1'h1, t);
    chk(t >= 10 && t <= 23, 1'h1, "gate delay");
    chk(pass_fail_output, 1'h0, "pass shown as fail");
    wt(1, 1'h0, h);
    chk(h >= 28 && h <= 32, 1'h1, "gate on time");
    pass_in <= 1'h0;
    pulse();
    wt(0, 1'h0, t);
    wt(1, 1'h1, t);
    chk(pass_fail_output, 1'h1, "fail not asserted");
    $display("test single done");
  endtask
  task automatic t_refuse();
    int t;
    dly <= 8'd40;
    n0 = nstart;
    pulse();
    pulse();
    cyc(2);
    chk(error_out, 1'h1, "error flag not raised");
    chk(irq, 1'h0, "masked irq raised");
    wr(A_MASK, 32'h2);
    chk(irq, 1'h1, "irq missing");
    wr(A_IRQ, 32'h2);
    chk(irq, 1'h0, "irq not cleared");
    wt(0, 1'h0, t);
    chk(nstart - n0, 1, "refused strobe read");
    pulse();
    chk(busy, 1'h1, "strobe not taken");
    chk(error_out, 1'h0, "error flag kept");
    wt(0, 1'h0, t);
    wr(A_CTRL, 32'h0);
    pulse();
    pulse();
    cyc(2);
    chk(error_out, 1'h0, "error flag while off");
    wt(0, 1'h0, t);
    chk(nstart - n0, 3, "refused strobe read");
    wr(A_IRQ, 32'h7);
    dly <= 8'h03;
    $display("test refuse done");
  endtask
  task automatic t_repeat();
    int t;
    pass_in <= 1'h1;
    wr(A_CTRL, 32'h0001_0001);
    n0 = nstart;
    repeat_read_level <= 1'h1;
    cyc(60);
    repeat_read_level <= 1'h0;
    wt(0, 1'h0, t);
    chk(nstart - n0 >= 5, 1'h1, "continuous stopped");
    cyc(200);
    chk(pass_fail_output, 1'h0, "pass not published");
    wr(A_CTRL, 32'h0001_0003);
    pass_in <= 1'h0;
    n0 = nstart;
    repeat_read_level <= 1'h1;
    cyc(60);
    chk(nstart - n0 >= 4, 1'h1, "level mode stopped");
    chk(pass_fail_output, 1'h0, "fail shown early");
    repeat_read_level <= 1'h0;
    wt(0, 1'h0, t);
    cyc(150);
    chk(pass_fail_output, 1'h1, "fail at release");
    pass_in <= 1'h1;
    n0 = nstart;
    repeat_read_level <= 1'h1;
    cyc(60);
    chk({busy, 4'(nstart - n0)}, 5'h01, "pass end");
    repeat_read_level <= 1'h0;
    cyc(10);
    pass_in <= 1'h0;
    n0 = nstart;
    pulse();
    wt(0, 1'h0, t);
    chk(nstart - n0, 2, "single retry count");
    pass_in <= 1'h1;
    $display("test repeat done");
  endtask
  task automatic t_scene();
    int t;
    wr(A_CTRL, 32'h0000_9501);
    scene_jump_level_one <= 1'h1;
    wt(0, 1'h1, t);
    chk(read_scene, 4'h5, "jump one scene");
    scene_jump_level_one <= 1'h0;
    wt(0, 1'h0, t);
    cyc(10);
    scene_jump_level_two <= 1'h1;
    wt(0, 1'h1, t);
    chk(read_scene, 4'h9, "jump two scene");
    scene_jump_level_two <= 1'h0;
    wt(0, 1'h0, t);
    wr(A_CTRL, 32'h5);
    pulse();
    wt(0, 1'h0, t);
    cyc(120);
    chk(pass_fail_output, 1'h1, "pass polarity");
    $display("test scene done");
  endtask

  task automatic test_done();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    cyc(10);
    aresetn <= 1'h1;
    cyc(2);
    t_regs();
    t_single();
    t_refuse();
    t_repeat();
    t_scene();
    test_done();
  end
  // All scenarios take about a thousand cycles
  initial begin
    cyc(20000);
    n_mismatch++;
    test_done();
  end
endmodule
